// ==== hw/nvb_defines.svh ====
// Constants for the byte-wide memory bus interface
`ifndef NVB_DEFINES_SVH
`define NVB_DEFINES_SVH

`define NVB_NV_ADDR_W     15
`define NVB_DATA_W        8
`define NVB_CPU_ADDR_W    16
`define NVB_NV_TOP_ADDR   16'h7fff
`define NVB_NV_INV_MASK   15'h6000
`define NVB_KEEP_BIT      14
`define NVB_CNT_W         4
`define NVB_NV_SETUP_CYC  4'h1
`define NVB_NV_STROBE_CYC 4'h2
`define NVB_ALE_CYC       4'h1
`define NVB_HOLD_CYC      4'h1
`define NVB_STROBE_CYC    4'h3
`define NVB_END_CYC       4'h1
`define NVB_NV_ADDR_RST   15'h6000

`endif

// ==== hw/nvb_pkg.sv ====
// Types shared by the byte-wide memory bus interface
package nvb_pkg;
`include "nvb_defines.svh"

	typedef enum logic [1:0] {
		NVB_TGT_PRIMARY,
		NVB_TGT_DATA_BANK,
		NVB_TGT_EXPANDED
	} nvb_target_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_NV_SETUP,
		ST_NV_STROBE,
		ST_NV_END,
		ST_EXP_ADDR,
		ST_EXP_HOLD,
		ST_EXP_STROBE,
		ST_EXP_END
	} nvb_state_type;

	typedef struct packed {
		logic                         valid;
		logic                         write;
		logic                         prog;
		logic [`NVB_CPU_ADDR_W-1:0]   addr;
		logic [`NVB_DATA_W-1:0]       wdata;
	} nvb_req_type;

	typedef struct packed {
		nvb_target_type target;
		logic           write_ok;
	} nvb_dec_type;

	typedef struct packed {
		logic [`NVB_NV_ADDR_W-1:0] nv_addr;
		logic [`NVB_DATA_W-1:0]    nv_data_out;
		logic                      nv_data_oe;
		logic                      nv_write_en_n;
		logic                      cs_primary_n;
		logic                      cs_bank_n;
		logic                      pse_n;
		logic                      pse_oe;
		logic                      ale;
		logic [`NVB_DATA_W-1:0]    mux_out;
		logic [`NVB_DATA_W-1:0]    mux_oe;
		logic [`NVB_DATA_W-1:0]    high_addr;
		logic                      wr_n;
		logic                      rd_n;
	} nvb_pins_type;
endpackage

// ==== hw/nvb_addr_decode.sv ====
// Address decode for the byte-wide and expanded buses
`timescale 1ns/1ns
`include "nvb_defines.svh"
module nvb_addr_decode
	import nvb_pkg::*;
(
	input  wire nvb_req_type                i_req,
	input  wire logic [`NVB_CPU_ADDR_W-1:0] i_partition_bound,
	input  wire logic                       i_data_bank_sel,
	input  wire logic                       i_external_access_sel,
	output nvb_dec_type                     o_dec
);
	always_comb begin
		o_dec.target   = NVB_TGT_EXPANDED;
		o_dec.write_ok = 1'b1;
		if (!i_external_access_sel) begin
			o_dec.target = NVB_TGT_EXPANDED;
		end else if (!i_req.prog && i_data_bank_sel) begin
			o_dec.target = NVB_TGT_DATA_BANK;
		end else if (i_req.addr <= `NVB_NV_TOP_ADDR) begin
			o_dec.target = NVB_TGT_PRIMARY;
			// Writes below the bound are dropped, not refused
			o_dec.write_ok = (i_req.addr >= i_partition_bound);
		end
	end
endmodule

// ==== hw/nvb_bus_if.sv ====
// Byte-wide nonvolatile memory bus and expanded bus sequencer
`timescale 1ns/1ns
`include "nvb_defines.svh"
module nvb_bus_if
	import nvb_pkg::*;
(
	input  wire logic                       I_MCLK,
	input  wire logic                       I_SRST,
	input  wire nvb_req_type                I_REQ,
	input  wire logic [`NVB_CPU_ADDR_W-1:0] I_PARTITION_BOUND,
	input  wire logic                       I_DATA_BANK_SEL,
	input  wire logic                       I_EXTERNAL_ACCESS_SEL,
	input  wire logic                       I_SUPPLY_BELOW_BACKUP,
	input  wire logic [`NVB_DATA_W-1:0]     I_NV_DATA_IN,
	input  wire logic [`NVB_DATA_W-1:0]     I_MUX_ADDR_DATA_PORT_IN,
	input  wire logic [`NVB_DATA_W-1:0]     I_PORT0_LATCH,
	input  wire logic [`NVB_DATA_W-1:0]     I_PORT2_LATCH,
	input  wire logic                       I_PROG_STORE_EN_N_IN,
	output logic [`NVB_NV_ADDR_W-1:0]       O_NV_ADDR,
	output logic [`NVB_DATA_W-1:0]          O_NV_DATA_OUT,
	output logic                            O_NV_DATA_OE,
	output logic                            O_NV_WRITE_EN_N,
	output logic                            O_NV_CHIP_SEL_PRIMARY_N,
	output logic                            O_NV_CHIP_SEL_DATA_BANK_N,
	output logic                            O_PROG_STORE_EN_N_OUT,
	output logic                            O_PROG_STORE_EN_N_OE,
	output logic                            O_ADDR_LATCH_EN,
	output logic [`NVB_DATA_W-1:0]          O_MUX_ADDR_DATA_PORT_OUT,
	output logic [`NVB_DATA_W-1:0]          O_MUX_ADDR_DATA_PORT_OE,
	output logic [`NVB_DATA_W-1:0]          O_HIGH_ADDR_PORT,
	output logic                            O_EXT_WRITE_STROBE_N,
	output logic                            O_EXT_READ_STROBE_N,
	output logic                            O_BUSY,
	output logic                            O_DONE,
	output logic [`NVB_DATA_W-1:0]          O_RDATA,
	output logic                            O_BOOT_LOADER_REQ,
	output logic                            O_INTERNAL_MEM_DIS
);
	nvb_state_type                state_ff;
	nvb_state_type                nxt_state;
	logic [`NVB_CNT_W-1:0]        cnt_ff;
	logic [`NVB_CNT_W-1:0]        nxt_cnt;
	nvb_target_type               tgt_ff;
	nvb_target_type               nxt_tgt;
	logic                         wr_ff;
	logic                         nxt_wr;
	logic                         prog_ff;
	logic                         nxt_prog;
	logic                         wok_ff;
	logic                         nxt_wok;
	logic [`NVB_CPU_ADDR_W-1:0]   addr_ff;
	logic [`NVB_CPU_ADDR_W-1:0]   nxt_addr;
	logic [`NVB_DATA_W-1:0]       wdata_ff;
	logic [`NVB_DATA_W-1:0]       nxt_wdata;
	logic [`NVB_DATA_W-1:0]       rdata_ff;
	logic [`NVB_DATA_W-1:0]       nxt_rdata;
	logic                         done_ff;
	logic                         nxt_done;
	logic                         busy_ff;
	logic                         nxt_busy;
	logic                         mem_dis_ff;
	logic                         nxt_mem_dis;
	logic                         boot_ff;
	logic                         nxt_boot;
	nvb_pins_type                 pins_ff;
	nvb_pins_type                 nxt_pins;
	nvb_dec_type                  dec;
	logic                         accept;

	nvb_addr_decode u_decode (
		.i_req                 (I_REQ),
		.i_partition_bound     (I_PARTITION_BOUND),
		.i_data_bank_sel       (I_DATA_BANK_SEL),
		.i_external_access_sel (I_EXTERNAL_ACCESS_SEL),
		.o_dec                 (dec)
	);

	function automatic logic [`NVB_CNT_W-1:0] phase_len(input nvb_state_type st);
		unique case (st)
			ST_NV_SETUP:   phase_len = `NVB_NV_SETUP_CYC;
			ST_NV_STROBE:  phase_len = `NVB_NV_STROBE_CYC;
			ST_EXP_ADDR:   phase_len = `NVB_ALE_CYC;
			ST_EXP_HOLD:   phase_len = `NVB_HOLD_CYC;
			ST_EXP_STROBE: phase_len = `NVB_STROBE_CYC;
			ST_IDLE, ST_NV_END, ST_EXP_END: phase_len = `NVB_END_CYC;
		endcase
	endfunction

	function automatic nvb_state_type follow(input nvb_state_type st);
		unique case (st)
			ST_NV_SETUP:   follow = ST_NV_STROBE;
			ST_NV_STROBE:  follow = ST_NV_END;
			ST_EXP_ADDR:   follow = ST_EXP_HOLD;
			ST_EXP_HOLD:   follow = ST_EXP_STROBE;
			ST_EXP_STROBE: follow = ST_EXP_END;
			ST_IDLE, ST_NV_END, ST_EXP_END: follow = ST_IDLE;
		endcase
	endfunction

	// Sequencer and latched request
	always_comb begin
		accept    = I_REQ.valid && (state_ff == ST_IDLE) && !I_SUPPLY_BELOW_BACKUP;
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_tgt   = tgt_ff;
		nxt_wr    = wr_ff;
		nxt_prog  = prog_ff;
		nxt_wok   = wok_ff;
		nxt_addr  = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_tgt   = dec.target;
					// Fetches never write, whatever the request says
					nxt_wr    = I_REQ.write && !I_REQ.prog;
					nxt_prog  = I_REQ.prog;
					nxt_wok   = dec.write_ok;
					nxt_addr  = I_REQ.addr;
					nxt_wdata = I_REQ.wdata;
					nxt_state = (dec.target == NVB_TGT_EXPANDED) ? ST_EXP_ADDR : ST_NV_SETUP;
					nxt_cnt   = phase_len(nxt_state);
				end
			end
			ST_NV_SETUP, ST_NV_STROBE, ST_NV_END,
			ST_EXP_ADDR, ST_EXP_HOLD, ST_EXP_STROBE, ST_EXP_END: begin
				if (cnt_ff == `NVB_CNT_W'(1)) begin
					nxt_state = follow(state_ff);
					nxt_cnt   = phase_len(nxt_state);
				end else begin
					nxt_cnt = cnt_ff - `NVB_CNT_W'(1);
				end
			end
		endcase
		if (cnt_ff == `NVB_CNT_W'(1) && !wr_ff) begin
			if (state_ff == ST_NV_STROBE) begin
				nxt_rdata = I_NV_DATA_IN;
			end else if (state_ff == ST_EXP_STROBE) begin
				nxt_rdata = I_MUX_ADDR_DATA_PORT_IN;
			end
		end
		// A supply drop aborts whatever cycle is running
		if (I_SUPPLY_BELOW_BACKUP) begin
			nxt_state = ST_IDLE;
			nxt_cnt   = `NVB_END_CYC;
		end
		nxt_done    = (nxt_state == ST_NV_END) || (nxt_state == ST_EXP_END);
		nxt_busy    = (nxt_state != ST_IDLE) || I_SUPPLY_BELOW_BACKUP;
		nxt_mem_dis = !I_EXTERNAL_ACCESS_SEL;
	end

	// Pin values follow the next state so that pins and state move together
	always_comb begin
		nxt_pins               = pins_ff;
		nxt_pins.nv_data_out   = nxt_wdata;
		nxt_pins.nv_data_oe    = 1'b0;
		nxt_pins.nv_write_en_n = 1'b1;
		nxt_pins.cs_primary_n  = 1'b1;
		nxt_pins.cs_bank_n     = 1'b1;
		nxt_pins.pse_n         = 1'b1;
		nxt_pins.pse_oe        = 1'b1;
		nxt_pins.ale           = 1'b0;
		nxt_pins.mux_out       = '0;
		nxt_pins.mux_oe        = ~I_PORT0_LATCH;
		nxt_pins.high_addr     = I_PORT2_LATCH;
		nxt_pins.wr_n          = 1'b1;
		nxt_pins.rd_n          = 1'b1;
		unique case (nxt_state)
			ST_IDLE: begin
			end
			ST_NV_SETUP, ST_NV_STROBE, ST_NV_END: begin
				nxt_pins.nv_addr = nxt_addr[`NVB_NV_ADDR_W-1:0] ^ `NVB_NV_INV_MASK;
				nxt_pins.mux_oe  = ~I_PORT0_LATCH;
				if (nxt_state != ST_NV_END) begin
					nxt_pins.cs_primary_n = (nxt_tgt != NVB_TGT_PRIMARY);
					nxt_pins.cs_bank_n    = (nxt_tgt != NVB_TGT_DATA_BANK);
					nxt_pins.nv_data_oe   = nxt_wr;
				end
				if (nxt_state == ST_NV_STROBE) begin
					nxt_pins.nv_write_en_n = !(nxt_wr && nxt_wok);
				end
			end
			ST_EXP_ADDR, ST_EXP_HOLD, ST_EXP_STROBE, ST_EXP_END: begin
				nxt_pins.high_addr = nxt_addr[`NVB_CPU_ADDR_W-1:`NVB_DATA_W];
				nxt_pins.mux_out   = nxt_addr[`NVB_DATA_W-1:0];
				nxt_pins.mux_oe    = '1;
				nxt_pins.ale       = (nxt_state == ST_EXP_ADDR);
				if (nxt_state == ST_EXP_STROBE || nxt_state == ST_EXP_END) begin
					nxt_pins.mux_out = nxt_wdata;
					nxt_pins.mux_oe  = nxt_wr ? '1 : '0;
				end
				if (nxt_state == ST_EXP_STROBE) begin
					nxt_pins.wr_n  = !nxt_wr;
					nxt_pins.rd_n  = nxt_wr || nxt_prog;
					nxt_pins.pse_n = !nxt_prog;
				end
			end
		endcase
		if (I_SUPPLY_BELOW_BACKUP) begin
			// Only bit 14 is backed; the rest fall with the supply
			nxt_pins.nv_addr = '0;
			nxt_pins.nv_addr[`NVB_KEEP_BIT] = pins_ff.nv_addr[`NVB_KEEP_BIT];
			nxt_pins.cs_primary_n  = 1'b1;
			nxt_pins.cs_bank_n     = 1'b1;
			nxt_pins.nv_write_en_n = 1'b1;
			nxt_pins.nv_data_oe    = 1'b0;
		end
	end

	// Loader entry is sampled only while reset is held
	always_comb begin
		nxt_boot = I_SRST ? !I_PROG_STORE_EN_N_IN : boot_ff;
	end

	always_ff @(posedge I_MCLK) begin
		boot_ff <= nxt_boot;
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			state_ff   <= ST_IDLE;
			cnt_ff     <= `NVB_END_CYC;
			tgt_ff     <= NVB_TGT_EXPANDED;
			wr_ff      <= 1'b0;
			prog_ff    <= 1'b0;
			wok_ff     <= 1'b0;
			addr_ff    <= '0;
			wdata_ff   <= '0;
			rdata_ff   <= '0;
			done_ff    <= 1'b0;
			busy_ff    <= 1'b1;
			mem_dis_ff <= 1'b0;
			pins_ff    <= '{nv_addr: `NVB_NV_ADDR_RST, nv_data_out: '0, nv_data_oe: 1'b0,
				nv_write_en_n: 1'b1, cs_primary_n: 1'b1, cs_bank_n: 1'b1, pse_n: 1'b1,
				pse_oe: 1'b0, ale: 1'b0, mux_out: '0, mux_oe: '0, high_addr: '1,
				wr_n: 1'b1, rd_n: 1'b1};
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			tgt_ff     <= nxt_tgt;
			wr_ff      <= nxt_wr;
			prog_ff    <= nxt_prog;
			wok_ff     <= nxt_wok;
			addr_ff    <= nxt_addr;
			wdata_ff   <= nxt_wdata;
			rdata_ff   <= nxt_rdata;
			done_ff    <= nxt_done;
			busy_ff    <= nxt_busy;
			mem_dis_ff <= nxt_mem_dis;
			pins_ff    <= nxt_pins;
		end
	end

	assign O_NV_ADDR                 = pins_ff.nv_addr;
	assign O_NV_DATA_OUT             = pins_ff.nv_data_out;
	assign O_NV_DATA_OE              = pins_ff.nv_data_oe;
	assign O_NV_WRITE_EN_N           = pins_ff.nv_write_en_n;
	assign O_NV_CHIP_SEL_PRIMARY_N   = pins_ff.cs_primary_n;
	assign O_NV_CHIP_SEL_DATA_BANK_N = pins_ff.cs_bank_n;
	assign O_PROG_STORE_EN_N_OUT     = pins_ff.pse_n;
	assign O_PROG_STORE_EN_N_OE      = pins_ff.pse_oe;
	assign O_ADDR_LATCH_EN           = pins_ff.ale;
	assign O_MUX_ADDR_DATA_PORT_OUT  = pins_ff.mux_out;
	assign O_MUX_ADDR_DATA_PORT_OE   = pins_ff.mux_oe;
	assign O_HIGH_ADDR_PORT          = pins_ff.high_addr;
	assign O_EXT_WRITE_STROBE_N      = pins_ff.wr_n;
	assign O_EXT_READ_STROBE_N       = pins_ff.rd_n;
	assign O_BUSY                    = busy_ff;
	assign O_DONE                    = done_ff;
	assign O_RDATA                   = rdata_ff;
	assign O_BOOT_LOADER_REQ         = boot_ff;
	assign O_INTERNAL_MEM_DIS        = mem_dis_ff;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SRST);

	sequence s_nv_start;
		accept && (dec.target != NVB_TGT_EXPANDED);
	endsequence

	sequence s_ale_then_hold;
		pins_ff.ale ##1 (!pins_ff.ale && pins_ff.mux_out == addr_ff[7:0] && pins_ff.mux_oe == 8'hff);
	endsequence

	a_supply_low_selects: assert property (I_SUPPLY_BELOW_BACKUP |=>
		pins_ff.cs_primary_n && pins_ff.cs_bank_n && pins_ff.nv_write_en_n)
		else $error("select active during supply drop");
	a_bit14_kept: assert property (I_SUPPLY_BELOW_BACKUP |=>
		pins_ff.nv_addr[14] == $past(pins_ff.nv_addr[14]))
		else $error("address bit 14 lost its state");
	a_addr_inverted: assert property ((state_ff == ST_NV_STROBE) |->
		pins_ff.nv_addr == (addr_ff[14:0] ^ 15'h6000))
		else $error("byte-wide address not inverted in top bits");
	a_one_select: assert property (!pins_ff.cs_primary_n || !pins_ff.cs_bank_n |->
		pins_ff.cs_primary_n != pins_ff.cs_bank_n && !pins_ff.ale && pins_ff.rd_n
		&& pins_ff.wr_n && pins_ff.pse_n)
		else $error("two selects in one access");
	a_write_protect: assert property ((state_ff == ST_NV_STROBE && !wok_ff) |->
		pins_ff.nv_write_en_n)
		else $error("write to protected region");
	a_ale_addr_latch: assert property ($rose(pins_ff.ale) |->
		pins_ff.high_addr == addr_ff[15:8] ##0 s_ale_then_hold)
		else $error("address latch sequence wrong");
	a_gpio_open_drain: assert property ((state_ff == ST_IDLE) |->
		pins_ff.mux_out == 8'h00)
		else $error("shared port drives high as I/O");
	a_exp_strobes: assert property ((state_ff == ST_EXP_STROBE) |->
		(pins_ff.wr_n == !wr_ff) && (pins_ff.pse_n == !prog_ff)
		&& (pins_ff.rd_n == (wr_ff || prog_ff)))
		else $error("expanded strobe wrong");
	a_bank_off_port: assert property ((state_ff == ST_NV_STROBE) |->
		!pins_ff.ale && pins_ff.wr_n && pins_ff.rd_n && pins_ff.pse_n)
		else $error("byte-wide access seen on expanded bus");
	a_nv_done_time: assert property (s_nv_start ##1 (!I_SUPPLY_BELOW_BACKUP)[*3] |=>
		done_ff && state_ff == ST_NV_END)
		else $error("byte-wide access not done in time");
	a_ea_low_expanded: assert property ((accept && !I_EXTERNAL_ACCESS_SEL) |=>
		state_ff == ST_EXP_ADDR && mem_dis_ff)
		else $error("external access low not expanded");
	a_low_half_primary: assert property ((accept && I_EXTERNAL_ACCESS_SEL && I_REQ.prog
		&& I_REQ.addr <= 16'h7fff) |=> tgt_ff == NVB_TGT_PRIMARY)
		else $error("low half not mapped to primary");
	a_boot_capture: assert property (@(posedge I_MCLK) disable iff (1'b0)
		(I_SRST && !I_PROG_STORE_EN_N_IN) |=> boot_ff)
		else $error("loader entry not captured");
endmodule

// ==== tb/nvb_mem_model.sv ====
// External static RAMs and expanded-bus memory facing the interface
`timescale 1ns/1ns
`include "nvb_defines.svh"
module nvb_mem_model
	import nvb_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic [`NVB_NV_ADDR_W-1:0] i_nv_addr,
	input  wire logic [7:0]                i_nv_dout,
	input  wire logic                      i_nv_oe,
	input  wire logic                      i_we_n,
	input  wire logic                      i_cs_p_n,
	input  wire logic                      i_cs_b_n,
	input  wire logic                      i_ale,
	input  wire logic [7:0]                i_mux,
	input  wire logic                      i_wr_n,
	input  wire logic                      i_rd_n,
	input  wire logic                      i_pse_n,
	output logic      [7:0]                o_nv_q,
	output logic                           o_mux_drv,
	output logic      [7:0]                o_mux_q
);
	logic [7:0]  prim_mem [0:8191];
	logic [7:0]  bank_mem [0:8191];
	logic [7:0]  ext_mem [0:255];
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  lo_lat = 8'h00;
	logic [12:0] a;
	logic        drv;

	// 8k parts: the two upper address lines stay open
	assign a = i_nv_addr[12:0];
	assign drv = (!i_cs_p_n || !i_cs_b_n) && !i_nv_oe && i_we_n;
	// Released bus shows the inverse of its last value, never a stale match
	assign o_nv_q = drv ? (!i_cs_p_n ? prim_mem[a] : bank_mem[a]) : ~last_q;
	// Partial decode on the low byte only; tests avoid aliases
	assign o_mux_drv = !i_rd_n || !i_pse_n;
	assign o_mux_q = ext_mem[lo_lat];

	always @(posedge i_clk) begin
		last_q <= o_nv_q;
		if (i_ale) begin
			lo_lat <= i_mux;
		end
		if (!i_we_n && !i_cs_p_n) begin
			prim_mem[a] <= i_nv_dout;
		end
		if (!i_we_n && !i_cs_b_n) begin
			bank_mem[a] <= i_nv_dout;
		end
		if (!i_wr_n) begin
			ext_mem[lo_lat] <= i_mux;
		end
	end
endmodule

// ==== tb/tb_nv_sram_bytewide_bus_interface.sv ====
// Self-checking bench for the byte-wide and expanded bus interface
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_nv_sram_bytewide_bus_interface;
	import nvb_pkg::*;
	logic        clk, srst, bank_sel, ea, supply, ext_pull, pse_lvl, mux_drv;
	nvb_req_type req;
	logic [15:0] bound;
	logic [14:0] nv_addr, cap_nv;
	logic [7:0]  p0_latch, p2_latch, nv_q, nv_dout, mux_lvl, mux_out, mux_oe, mux_q, high, rdata;
	logic [7:0]  cap_mux, cap_oe, cap_hi, cap_wd;
	logic        nv_oe, we_n, cs_p_n, cs_b_n, pse_out, pse_oe, ale, wr_n, rd_n;
	logic        busy, done, boot_req, mem_dis;
	logic        s_p, s_b, s_we, s_ale, s_rd, s_wr, s_pse, got;
	int          miscompares, check_count, lat;

	// Open-drain loader pull wins whether or not the device drives the pin
	assign pse_lvl = (pse_oe ? pse_out : 1'b1) & ~ext_pull;
	assign mux_lvl = (mux_oe & mux_out) | (~mux_oe & (mux_drv ? mux_q : 8'hff));

	nvb_bus_if uut (.I_MCLK(clk), .I_SRST(srst), .I_REQ(req), .I_PARTITION_BOUND(bound),
		.I_DATA_BANK_SEL(bank_sel), .I_EXTERNAL_ACCESS_SEL(ea),
		.I_SUPPLY_BELOW_BACKUP(supply), .I_NV_DATA_IN(nv_q),
		.I_MUX_ADDR_DATA_PORT_IN(mux_lvl), .I_PORT0_LATCH(p0_latch),
		.I_PORT2_LATCH(p2_latch), .I_PROG_STORE_EN_N_IN(pse_lvl), .O_NV_ADDR(nv_addr),
		.O_NV_DATA_OUT(nv_dout), .O_NV_DATA_OE(nv_oe), .O_NV_WRITE_EN_N(we_n),
		.O_NV_CHIP_SEL_PRIMARY_N(cs_p_n), .O_NV_CHIP_SEL_DATA_BANK_N(cs_b_n),
		.O_PROG_STORE_EN_N_OUT(pse_out), .O_PROG_STORE_EN_N_OE(pse_oe),
		.O_ADDR_LATCH_EN(ale), .O_MUX_ADDR_DATA_PORT_OUT(mux_out),
		.O_MUX_ADDR_DATA_PORT_OE(mux_oe), .O_HIGH_ADDR_PORT(high),
		.O_EXT_WRITE_STROBE_N(wr_n), .O_EXT_READ_STROBE_N(rd_n), .O_BUSY(busy),
		.O_DONE(done), .O_RDATA(rdata), .O_BOOT_LOADER_REQ(boot_req),
		.O_INTERNAL_MEM_DIS(mem_dis));

	nvb_mem_model mem (.i_clk(clk), .i_nv_addr(nv_addr), .i_nv_dout(nv_dout), .i_nv_oe(nv_oe),
		.i_we_n(we_n), .i_cs_p_n(cs_p_n), .i_cs_b_n(cs_b_n), .i_ale(ale), .i_mux(mux_lvl),
		.i_wr_n(wr_n), .i_rd_n(rd_n), .i_pse_n(pse_out | ~pse_oe), .o_nv_q(nv_q),
		.o_mux_drv(mux_drv), .o_mux_q(mux_q));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One access; strobe activity is recorded once per cycle, at the falling edge
	task automatic access(input logic w, input logic p, input logic [15:0] a,
		input logic [7:0] d, input int abort_at);
		{s_p, s_b, s_we, s_ale, s_rd, s_wr, s_pse, got} = '0;
		lat = -1;
		@(posedge clk);
		req <= '{1'b1, w, p, a, d};
		for (int n = 0; n < 12 && !got; n++) begin
			@(posedge clk);
			req.valid <= 1'b0;
			if (n == abort_at) begin
				supply <= 1'b1;
			end
			@(negedge clk);
			if (n == 0) begin
				{cap_nv, cap_mux, cap_oe, cap_hi} = {nv_addr, mux_out, mux_oe, high};
			end
			s_p |= !cs_p_n;
			s_b |= !cs_b_n;
			s_we |= !we_n;
			s_ale |= ale;
			s_rd |= !rd_n;
			s_pse |= !pse_out;
			if (!wr_n) begin
				s_wr = 1'b1;
				cap_wd = mux_out;
			end
			got = done;
			lat = n;
		end
	endtask

	task automatic do_reset(input logic pull);
		@(posedge clk);
		srst <= 1'b1;
		// Pull only once the device already sits in reset
		@(posedge clk);
		ext_pull <= pull;
		@(posedge clk);
		@(negedge clk);
		`CHK("rst_nv_addr", 15'h6000, nv_addr)
		`CHK("rst_sel", 2'b11, {cs_p_n, cs_b_n})
		`CHK("rst_pse_oe", 1'b0, pse_oe)
		@(posedge clk);
		srst <= 1'b0;
		ext_pull <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK("boot_req", pull, boot_req)
		`CHK("pse_idle", 2'b11, {pse_oe, pse_out})
	endtask

	task automatic t_nv_rw();
		access(1, 0, 16'h1abc, 8'h5a, -1);
		`CHK("nv_addr", 15'h7abc, cap_nv)
		`CHK("nv_sel", 3'b100, {s_p, s_b, s_ale})
		`CHK("we_seen", 1'b1, s_we)
		`CHK("nv_lat", 3, lat)
		access(1, 0, 16'h7fff, 8'hc3, -1);
		`CHK("nv_top", 15'h1fff, cap_nv)
		access(0, 0, 16'h1abc, 8'h00, -1);
		`CHK("rd_1abc", 8'h5a, rdata)
		access(0, 0, 16'h7fff, 8'h00, -1);
		`CHK("rd_7fff", 8'hc3, rdata)
	endtask

	task automatic t_protect();
		access(1, 0, 16'h0100, 8'h11, -1);
		@(posedge clk);
		bound <= 16'h2000;
		access(1, 0, 16'h0100, 8'hee, -1);
		`CHK("prot_we", 2'b01, {s_we, got})
		access(0, 1, 16'h0100, 8'h00, -1);
		`CHK("prot_rd", 8'h11, rdata)
		`CHK("fetch_nv", 2'b10, {s_p, s_pse})
		@(posedge clk);
		bound <= 16'h0000;
	endtask

	task automatic t_bank();
		@(posedge clk);
		bank_sel <= 1'b1;
		access(1, 0, 16'h0200, 8'h99, -1);
		`CHK("bank_sel", 4'b0100, {s_p, s_b, s_ale, s_wr})
		access(0, 0, 16'h0200, 8'h00, -1);
		`CHK("bank_rd", 8'h99, rdata)
		`CHK("bank_port", 2'b00, {s_ale, s_rd})
		@(posedge clk);
		bank_sel <= 1'b0;
	endtask

	task automatic t_exp();
		access(1, 0, 16'h8123, 8'h77, -1);
		`CHK("ale_addr", 24'h23ff81, {cap_mux, cap_oe, cap_hi})
		`CHK("exp_wr", 9'h177, {s_wr, cap_wd})
		`CHK("exp_sel", 3'b001, {s_p, s_b, s_ale})
		`CHK("exp_lat", 5, lat)
		access(0, 0, 16'h8123, 8'h00, -1);
		`CHK("exp_rd", 10'h277, {s_rd, s_pse, rdata})
		access(0, 1, 16'h8123, 8'h00, -1);
		`CHK("exp_fetch", 10'h177, {s_rd, s_pse, rdata})
	endtask

	task automatic t_ea_low();
		@(posedge clk);
		ea <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("mem_dis", 1'b1, mem_dis)
		access(1, 0, 16'h0010, 8'h3c, -1);
		`CHK("ea_route", 2'b01, {s_p, s_ale})
		access(0, 0, 16'h0010, 8'h00, -1);
		`CHK("ea_rd", 8'h3c, rdata)
		@(posedge clk);
		ea <= 1'b1;
	endtask

	task automatic t_gpio();
		@(posedge clk);
		p0_latch <= 8'h5a;
		p2_latch <= 8'h3c;
		repeat (2) @(negedge clk);
		`CHK("gpio_port", 16'ha500, {mux_oe, mux_out})
		`CHK("gpio_high", 8'h3c, high)
		@(posedge clk);
		p0_latch <= 8'hff;
		p2_latch <= 8'h00;
	endtask

	task automatic t_supply();
		access(1, 0, 16'h0010, 8'h42, 1);
		`CHK("abort_done", 1'b0, got)
		`CHK("abort_sel", 2'b11, {cs_p_n, cs_b_n})
		`CHK("keep_bit14", 15'h4000, nv_addr)
		@(posedge clk);
		supply <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("resume", 1'b0, busy)
	endtask

	initial begin
		{srst, bank_sel, ea, supply, ext_pull} = 5'b10100;
		req = '0;
		bound = 16'h0000;
		p0_latch = 8'hff;
		p2_latch = 8'h00;
		miscompares = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		do_reset(1'b1);
		do_reset(1'b0);
		t_nv_rw();
		t_protect();
		t_bank();
		t_exp();
		t_ea_low();
		t_gpio();
		t_supply();
		end_sim();
	end

	// A hang past 3000 cycles, far beyond the roughly 120 the run needs, ends the run
	initial begin
		#150000;
		miscompares++;
		end_sim();
	end
endmodule
